// ---- disk_drive_run_stop_sequencer.sv ----
// Run/stop sequencer of a cartridge disk drive with an APB register file.
// Assumes all drive and controller pins are asynchronous to core_clk.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "drive_seq_params.svh"
module disk_drive_run_stop_sequencer #(
  parameter int TICKS_PER_SEC = `CORE_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic motor_switch,
  input wire logic cartridge_interlock,
  input wire logic temp_ok,
  input wire logic spindle_upspeed,
  input wire logic brush_cycle_done,
  input wire logic addr_clear,
  input wire logic at_zero,
  input wire logic positioner_settled,
  input wire logic track_pulse,
  input wire logic track_dir_up,
  input wire logic unit_select,
  input wire logic write_enable,
  input wire logic read_enable,
  input wire logic raw_read_data,
  input wire logic disc_read_data,
  output logic spindle_start_relay,
  output logic brush_start_relay,
  output logic spindle_brake,
  output logic stop_light,
  output logic latch_release,
  output logic ready_light,
  output logic up_to_speed,
  output logic power_amp_enable,
  output logic carriage_fwd,
  output logic carriage_rev,
  output logic write_gate,
  output logic erase_gate,
  output logic write_current_low,
  output logic disc_in_data,
  output logic read_data_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [14:0] pin_raw;
  logic [14:0] sync1_reg;
  logic [14:0] sync2_reg;
  logic sw_on, interlock, temp, upspeed, brush_done, clr_ok, zero, settled;
  logic trk, trk_up, usel, wr_en, rd_en, raw_rd, disc_rd;
  logic trk_prev_reg;
  logic trk_edge;

  assign pin_raw = {disc_read_data, raw_read_data, read_enable, write_enable, unit_select,
                    track_dir_up, track_pulse, positioner_settled, at_zero, addr_clear,
                    brush_cycle_done, spindle_upspeed, temp_ok, cartridge_interlock,
                    motor_switch};

  // Two stages for every pin; only the second stage feeds logic.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 15'h0;
      sync2_reg <= 15'h0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign {disc_rd, raw_rd, rd_en, wr_en, usel, trk_up, trk, settled, zero, clr_ok,
          brush_done, upspeed, temp, interlock, sw_on} = sync2_reg;

  // Track pulses are counted on their rising edge.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trk_prev_reg <= 1'b0;
    end else begin
      trk_prev_reg <= trk;
    end
  end
  assign trk_edge = trk && !trk_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration, timers and state.
  drive_seq_pkg::seq_state_t state_reg;
  drive_seq_pkg::seq_state_t state_next;
  logic [1:0] ctrl_reg;
  logic [8:0] cyl_reg;
  logic [8:0] target_reg;
  logic stop_light_reg;
  logic start_ok;
  logic running;
  logic seq_start, seq_done, seq_busy;
  logic brake_start, brake_done, brake_busy;
  logic seek_complete;

  assign running = (state_reg != drive_seq_pkg::ST_IDLE) &&
                   (state_reg != drive_seq_pkg::ST_STOP);
  assign start_ok = sw_on && !stop_light_reg && interlock && temp;
  assign seq_start = (state_next == drive_seq_pkg::ST_DELAY ||
                      state_next == drive_seq_pkg::ST_STOP) && state_next != state_reg;
  assign brake_start = (state_next == drive_seq_pkg::ST_STOP) && running;
  assign seek_complete = (state_reg == drive_seq_pkg::ST_READY) && settled;

  second_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_seq_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(seq_start),
    .cancel(1'b0),
    .seconds(`SEQ_DELAY_S),
    .busy_reg(seq_busy),
    .done_reg(seq_done)
  );

  second_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_brake_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(brake_start),
    .cancel(1'b0),
    .seconds(`BRAKE_TIME_S),
    .busy_reg(brake_busy),
    .done_reg(brake_done)
  );

  // Sequence steps; switch off in any running step leads to the stop path.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      drive_seq_pkg::ST_IDLE: if (start_ok) state_next = drive_seq_pkg::ST_SPINUP;
      drive_seq_pkg::ST_SPINUP: begin
        if (upspeed) begin
          state_next = ctrl_reg[`CTRL_HIGH_DENSITY] ? drive_seq_pkg::ST_BRUSH
                                                     : drive_seq_pkg::ST_DELAY;
        end
      end
      drive_seq_pkg::ST_BRUSH: if (brush_done) state_next = drive_seq_pkg::ST_DELAY;
      drive_seq_pkg::ST_DELAY: if (seq_done) state_next = drive_seq_pkg::ST_LOAD;
      drive_seq_pkg::ST_LOAD: begin
        state_next = clr_ok ? drive_seq_pkg::ST_REV : drive_seq_pkg::ST_FWD;
      end
      drive_seq_pkg::ST_FWD: if (clr_ok) state_next = drive_seq_pkg::ST_REV;
      drive_seq_pkg::ST_REV: if (zero) state_next = drive_seq_pkg::ST_ZERO;
      drive_seq_pkg::ST_ZERO: if (trk_edge) state_next = drive_seq_pkg::ST_POS;
      drive_seq_pkg::ST_POS: if (zero && settled) state_next = drive_seq_pkg::ST_READY;
      drive_seq_pkg::ST_READY: state_next = drive_seq_pkg::ST_READY;
      drive_seq_pkg::ST_STOP: begin
        if (!seq_busy && zero) state_next = drive_seq_pkg::ST_IDLE;
      end
      default: state_next = drive_seq_pkg::ST_IDLE;
    endcase
    if (running && !sw_on) begin
      state_next = drive_seq_pkg::ST_STOP;
    end
  end

  // Reset always returns the sequence to idle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= drive_seq_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stop light is on out of reset; it goes out on the switch and returns after the stop delay.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stop_light_reg <= 1'b1;
    end else if (state_reg == drive_seq_pkg::ST_IDLE && sw_on) begin
      stop_light_reg <= 1'b0;
    end else if (state_reg == drive_seq_pkg::ST_STOP && state_next == drive_seq_pkg::ST_IDLE) begin
      stop_light_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cylinder position and target.
  // A forced load wins over counting; a pulse at the forced edge is lost on purpose.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cyl_reg <= 9'h0;
      target_reg <= 9'h0;
    end else if (state_reg == drive_seq_pkg::ST_LOAD) begin
      cyl_reg <= 9'h001;
      target_reg <= 9'h0;
    end else if (state_reg == drive_seq_pkg::ST_ZERO && trk_edge) begin
      cyl_reg <= 9'h0;
    end else if (trk_edge) begin
      cyl_reg <= trk_up ? cyl_reg - 9'h001 : cyl_reg + 9'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drive, carriage and indicator outputs, one cycle behind the state.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      spindle_start_relay <= 1'b0;
      brush_start_relay <= 1'b0;
      up_to_speed <= 1'b0;
      ready_light <= 1'b0;
      power_amp_enable <= 1'b0;
      carriage_fwd <= 1'b0;
      carriage_rev <= 1'b0;
      spindle_brake <= 1'b0;
      stop_light <= 1'b1;
      latch_release <= 1'b1;
    end else begin
      spindle_start_relay <= running;
      brush_start_relay <= running && ctrl_reg[`CTRL_HIGH_DENSITY];
      up_to_speed <= running && state_reg != drive_seq_pkg::ST_SPINUP;
      ready_light <= state_reg == drive_seq_pkg::ST_READY;
      power_amp_enable <= state_reg == drive_seq_pkg::ST_FWD ||
                          state_reg == drive_seq_pkg::ST_REV ||
                          state_reg == drive_seq_pkg::ST_ZERO ||
                          state_reg == drive_seq_pkg::ST_POS ||
                          state_reg == drive_seq_pkg::ST_READY ||
                          (state_reg == drive_seq_pkg::ST_STOP && !zero);
      carriage_fwd <= state_reg == drive_seq_pkg::ST_FWD;
      carriage_rev <= state_reg == drive_seq_pkg::ST_REV ||
                      (state_reg == drive_seq_pkg::ST_STOP && !zero);
      spindle_brake <= brake_busy;
      stop_light <= stop_light_reg;
      latch_release <= stop_light_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write and read data paths; writing is inhibited unless every gate is true.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      write_gate <= 1'b0;
      erase_gate <= 1'b0;
      write_current_low <= 1'b0;
      disc_in_data <= 1'b0;
      read_data_out <= 1'b0;
    end else begin
      write_gate <= usel && wr_en && seek_complete;
      erase_gate <= usel && wr_en && seek_complete;
      write_current_low <= usel && wr_en && seek_complete &&
                           (cyl_reg >= (ctrl_reg[`CTRL_HIGH_DENSITY] ? `INNER_ZONE_HIGH
                                                                     : `INNER_ZONE_LOW));
      disc_in_data <= usel && rd_en && ctrl_reg[`CTRL_DISC_FITTED] && raw_rd;
      read_data_out <= usel && rd_en &&
                       (ctrl_reg[`CTRL_DISC_FITTED] ? disc_rd : raw_rd);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, data and error decided in the setup cycle.
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_event;
  logic wr_access;
  logic setup;
  logic [31:0] rd_value;
  logic rd_hit;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;
  assign irq_event = {brake_done,
                      state_reg == drive_seq_pkg::ST_STOP && state_next == drive_seq_pkg::ST_IDLE,
                      state_reg != drive_seq_pkg::ST_READY &&
                      state_next == drive_seq_pkg::ST_READY};

  // Read mux for the addressed word.
  always_comb begin
    rd_value = 32'h0;
    rd_hit = 1'b1;
    unique case (paddr)
      `REG_CTRL: rd_value = {30'h0, ctrl_reg};
      `REG_STATUS: begin
        rd_value[3:0] = state_reg;
        rd_value[`STATUS_READY] = ready_light;
        rd_value[`STATUS_UPSPEED] = up_to_speed;
        rd_value[`STATUS_BRAKE] = spindle_brake;
        rd_value[`STATUS_STOP_LIGHT] = stop_light_reg;
        rd_value[`STATUS_CYL_LSB +: 9] = cyl_reg;
      end
      `REG_IRQ_STAT: rd_value = {29'h0, irq_stat_reg};
      `REG_IRQ_MASK: rd_value = {29'h0, irq_mask_reg};
      `REG_TARGET: rd_value = {23'h0, target_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // Bus answer registers; pready stays high once out of reset.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_value;
        pslverr <= !rd_hit;
      end
    end
  end

  // Writable configuration; the status and target words ignore writes.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `CTRL_RESET;
      irq_mask_reg <= 3'h0;
    end else if (wr_access && paddr == `REG_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end else if (wr_access && paddr == `REG_IRQ_MASK) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // Sticky events; a new event in the clearing cycle is kept.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_access && paddr == `REG_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_event;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_event;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_spindle_start: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(spindle_start_relay) |-> $past(start_ok, 2))
    else $error("spindle started without start conditions");
  chk_upspeed_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_SPINUP && !upspeed |=> !up_to_speed)
    else $error("up-to-speed set before up-speed report");
  chk_brush_skip: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_SPINUP && upspeed && sw_on &&
    !ctrl_reg[`CTRL_HIGH_DENSITY] |=> state_reg == drive_seq_pkg::ST_DELAY)
    else $error("brush wait taken in low density mode");
  chk_load_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_LOAD |=> cyl_reg == 9'h001 && target_reg == 9'h0)
    else $error("homing load wrong");
  chk_fwd_first: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_LOAD && !clr_ok && sw_on |=> ##1 carriage_fwd)
    else $error("carriage not moved forward through zero");
  chk_rev_drive: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_REV |=> carriage_rev && power_amp_enable)
    else $error("homing move not driven");
  chk_zero_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_ZERO && trk_edge |=> cyl_reg == 9'h0)
    else $error("counter not cleared at zero");
  chk_ready_on: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_POS && zero && settled && sw_on |=> ##1 ready_light)
    else $error("ready not raised");
  chk_write_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    write_gate |-> $past(wr_en && seek_complete && usel))
    else $error("write gated without enable and seek complete");
  chk_stop_drop: assert property (@(posedge core_clk) disable iff (!resetn)
    state_reg == drive_seq_pkg::ST_READY && !sw_on |=> ##1 !ready_light && !up_to_speed)
    else $error("ready kept after switch off");
endmodule : disk_drive_run_stop_sequencer
`default_nettype wire

// ---- drive_seq_params.svh ----
// Constants of the run/stop sequencer: register offsets, field positions, reset values, timing.
// Assumes a 50 MHz core clock and an APB bus with 32-bit data.
// Behaviour
// - Spindle and brush drives start only with switch on, stop light off, interlock made and temperature good.
// - The start waits for the spindle up-speed report, then sets the up-to-speed flag.
// - In high track density mode the start also waits for the brush sweep to finish.
// - After a ten second delay the target is loaded with zero and the position counter forced to one.
// - If address clear is not true, the carriage first moves forward through zero.
// - The first seek enables the power amplifier and drives the carriage back toward track zero.
// - At the zero position the next track pulse clears the position counter.
// - At zero with the positioner settled the drive becomes operational and ready lights.
// - Writing and edge erase are enabled only with write enable and seek complete, else inhibited.
// - While writing, reduced current is chosen at or above the inner-zone cylinder threshold.
// - Read data go through the discriminator when fitted, otherwise straight to the interface.
// - Switch off while running drops ready, clears up-to-speed and returns the carriage home.
// - After a ten second stop delay the stop light comes on and the latch releases.
// - Switch off applies the dynamic brake for twelve seconds.
// - The position counter counts down toward higher tracks and up toward lower tracks.
`ifndef DRIVE_SEQ_PARAMS_SVH
`define DRIVE_SEQ_PARAMS_SVH
`define CORE_CLK_HZ 50000000
`define SEQ_DELAY_S 4'ha
`define BRAKE_TIME_S 4'hc
`define INNER_ZONE_HIGH 9'h100
`define INNER_ZONE_LOW 9'h080
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_TARGET 12'h010
`define CTRL_HIGH_DENSITY 0
`define CTRL_DISC_FITTED 1
`define CTRL_RESET 2'h0
`define IRQ_READY 0
`define IRQ_STOPPED 1
`define IRQ_BRAKE_END 2
`define STATUS_READY 4
`define STATUS_UPSPEED 5
`define STATUS_BRAKE 6
`define STATUS_STOP_LIGHT 7
`define STATUS_CYL_LSB 16
`endif

// ---- drive_seq_pkg.sv ----
// Types shared by the run/stop sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package drive_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SPINUP = 4'h1,
    ST_BRUSH  = 4'h2,
    ST_DELAY  = 4'h3,
    ST_LOAD   = 4'h4,
    ST_FWD    = 4'h5,
    ST_REV    = 4'h6,
    ST_ZERO   = 4'h7,
    ST_POS    = 4'h8,
    ST_READY  = 4'h9,
    ST_STOP   = 4'ha
  } seq_state_t;
endpackage : drive_seq_pkg
`default_nettype wire

// ---- second_timer.sv ----
// Seconds down-counter fed by a prescaled one-second tick.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module second_timer #(
  parameter int TICKS_PER_SEC = 50000000
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic [3:0] seconds,
  output logic busy_reg,
  output logic done_reg
);
  logic [31:0] pre_reg;
  logic [3:0] secs_reg;
  logic tick;

  // The prescaler restarts on every start so the first second is whole.
  assign tick = (pre_reg == 32'(TICKS_PER_SEC - 1));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 32'h0;
    end else if (start || tick || !busy_reg) begin
      pre_reg <= 32'h0;
    end else begin
      pre_reg <= pre_reg + 32'h1;
    end
  end

  // Count whole seconds; done pulses once as the last second ends.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      secs_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        secs_reg <= seconds;
        busy_reg <= (seconds != 4'h0);
      end else if (cancel) begin
        busy_reg <= 1'b0;
      end else if (busy_reg && tick) begin
        secs_reg <= secs_reg - 4'h1;
        if (secs_reg == 4'h1) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule : second_timer
`default_nettype wire

// ---- drive_partner_model.sv ----
// Behavioural model of the drive mechanics: spindle, brush sweep and carriage with detent pulses.
// Assumes the sequencer outputs are registered levels on core_clk.
`timescale 1ns/1ps
`default_nettype none
module drive_partner_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic spindle_start_relay,
  input wire logic brush_start_relay,
  input wire logic power_amp_enable,
  input wire logic carriage_fwd,
  input wire logic carriage_rev,
  output logic spindle_upspeed,
  output logic brush_cycle_done,
  output logic addr_clear,
  output logic at_zero,
  output logic positioner_settled,
  output logic track_pulse,
  output logic track_dir_up
);
  logic [5:0] spin_cnt;
  logic [5:0] brush_cnt;
  logic [2:0] step;
  logic [3:0] pos;
  logic rest_pulse;
  logic rest_done;
  //////////////////////////////////////////////////////////////////////////////
  // Motors need time under power; dropping the relay loses all speed at once.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      spin_cnt <= 6'h00;
      brush_cnt <= 6'h00;
    end else begin
      spin_cnt <= !spindle_start_relay ? 6'h00 : spin_cnt + {5'h00, spin_cnt != 6'h3f};
      brush_cnt <= !brush_start_relay ? 6'h00 : brush_cnt + {5'h00, brush_cnt != 6'h3f};
    end
  end
  // The carriage moves one track every eight cycles in the commanded direction.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step <= 3'h0;
      pos <= 4'h0;
    end else begin
      step <= step + 3'h1;
      if (step == 3'h7 && carriage_fwd && pos != 4'hf) begin
        pos <= pos + 4'h1;
      end else if (step == 3'h7 && carriage_rev && pos != 4'h0) begin
        pos <= pos - 4'h1;
      end
    end
  end
  // A carriage at rest under power gives one fresh detent pulse, then stays quiet.
  // Without this limit a parked head would keep moving the position count away from zero.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rest_pulse <= 1'b0;
      rest_done <= 1'b0;
    end else if (carriage_fwd || carriage_rev || !power_amp_enable) begin
      rest_pulse <= 1'b0;
      rest_done <= 1'b0;
    end else if (step == 3'h3 && !rest_done) begin
      rest_pulse <= 1'b1;
      rest_done <= 1'b1;
    end else if (step == 3'h7) begin
      rest_pulse <= 1'b0;
    end
  end
  // Detent pulses follow carriage motion; a stopped head only gives its single rest pulse.
  assign spindle_upspeed = spin_cnt >= 6'h20;
  assign brush_cycle_done = brush_cnt == 6'h3f;
  assign at_zero = pos == 4'h0;
  assign addr_clear = pos >= 4'h2;
  assign positioner_settled = at_zero && !carriage_rev && !carriage_fwd;
  assign track_pulse = power_amp_enable && step[2] &&
                       (carriage_fwd || carriage_rev || rest_pulse);
  assign track_dir_up = carriage_fwd;
endmodule : drive_partner_model
`default_nettype wire

// ---- tb_disk_drive_run_stop_sequencer.sv ----
// Self-checking bench for the run/stop sequencer with APB access and a mechanics model.
// Assumes TICKS_PER_SEC of 10, so one second is ten core_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_disk_drive_run_stop_sequencer;
  logic core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, irq, rerr;
  logic motor_switch = 1'h0, cartridge_interlock = 1'h0, temp_ok = 1'h1, unit_select = 1'h0;
  logic write_enable = 1'h0, read_enable = 1'h0, raw_read_data = 1'h0, disc_read_data = 1'h0;
  logic spindle_upspeed, brush_cycle_done, addr_clear, at_zero, positioner_settled;
  logic track_pulse, track_dir_up, spindle_start_relay, brush_start_relay, spindle_brake;
  logic stop_light, latch_release, ready_light, up_to_speed, power_amp_enable, carriage_fwd;
  logic carriage_rev, write_gate, erase_gate, write_current_low, disc_in_data, read_data_out;
  int err_count = 0, total_checks = 0;
  disk_drive_run_stop_sequencer #(.TICKS_PER_SEC(10)) disk_drive_run_stop_sequencer_inst (.*);
  drive_partner_model drive_partner_model_inst (.*);
  // The clock toggles every half period of 10 ns.
  always #10 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; pready is sampled with the request held, so slow answers are waited for.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      tally_and_finish();
    end
  endtask : apb
  // Bounded wait for a level; a wait that runs out ends the run as a failure.
  task automatic wait_for(ref logic s, input logic v, input int n);
    int i;
    i = 0;
    while (s !== v && i < n) begin
      @(negedge core_clk);
      i++;
    end
    chk({31'h0, s}, {31'h0, v});
    if (s !== v) begin
      tally_and_finish();
    end
  endtask : wait_for
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, refused start, first seek, data paths, stop, dense run.
  initial begin
    repeat (6) @(negedge core_clk);
    chk({30'h0, stop_light, latch_release}, 32'h3);
    chk({31'h0, spindle_start_relay}, 32'h0);
    @(posedge core_clk);
    resetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk(rdata, 32'h0);
    apb(1'h0, 12'h014, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'h1, 12'h00c, 32'h7);
    // Switch on with the interlock open must not start anything.
    @(posedge core_clk);
    motor_switch <= 1'h1;
    repeat (20) @(negedge core_clk);
    chk({31'h0, spindle_start_relay}, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk({28'h0, rdata[3:0]}, 32'h0);
    @(posedge core_clk);
    cartridge_interlock <= 1'h1;
    wait_for(spindle_start_relay, 1'h1, 20);
    chk({31'h0, brush_start_relay}, 32'h0);
    wait_for(up_to_speed, 1'h1, 100);
    chk({31'h0, ready_light}, 32'h0);
    wait_for(ready_light, 1'h1, 1000);
    chk({31'h0, at_zero}, 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk({23'h0, rdata[24:16]}, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk(rdata, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, 12'h008, 32'h1);
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    // Writing follows write enable while seek complete is held true.
    @(posedge core_clk);
    unit_select <= 1'h1;
    write_enable <= 1'h1;
    repeat (6) @(negedge core_clk);
    chk({29'h0, write_gate, erase_gate, write_current_low}, 32'h6);
    @(posedge core_clk);
    write_enable <= 1'h0;
    repeat (6) @(negedge core_clk);
    chk({30'h0, write_gate, erase_gate}, 32'h0);
    // Both read routes, each with both data levels.
    @(posedge core_clk);
    read_enable <= 1'h1;
    for (int f = 0; f < 2; f++) begin
      apb(1'h1, 12'h000, {30'h0, f[0], 1'h0});
      for (int v = 0; v < 2; v++) begin
        @(posedge core_clk);
        raw_read_data <= v[0];
        disc_read_data <= !v[0];
        repeat (6) @(negedge core_clk);
        chk({31'h0, read_data_out}, {31'h0, f[0] ^ v[0]});
        chk({31'h0, disc_in_data}, {31'h0, f[0] & v[0]});
      end
    end
    // Stop: ready drops at once, the brake holds, the light waits out the delay.
    @(posedge core_clk);
    motor_switch <= 1'h0;
    repeat (8) @(negedge core_clk);
    chk({30'h0, ready_light, up_to_speed}, 32'h0);
    repeat (52) @(negedge core_clk);
    chk({30'h0, spindle_brake, stop_light}, 32'h2);
    wait_for(stop_light, 1'h1, 300);
    chk({31'h0, latch_release}, 32'h1);
    wait_for(spindle_brake, 1'h0, 300);
    apb(1'h0, 12'h008, 32'h0);
    chk(rdata, 32'h6);
    apb(1'h1, 12'h00c, 32'h0);
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, 12'h008, 32'h7);
    apb(1'h1, 12'h00c, 32'h7);
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    // Dense mode adds the brush sweep before the delay.
    apb(1'h1, 12'h000, 32'h1);
    @(posedge core_clk);
    motor_switch <= 1'h1;
    wait_for(brush_start_relay, 1'h1, 60);
    wait_for(ready_light, 1'h1, 1000);
    tally_and_finish();
  end
  // Hard limit so that a stuck sequence still produces a verdict.
  initial begin
    #400000;
    chk(32'h1, 32'h0);
    tally_and_finish();
  end
endmodule : tb_disk_drive_run_stop_sequencer
`default_nettype wire
